// ==== src/option_ref_defs.vh ====
`ifndef OPTION_REF_DEFS_VH
`define OPTION_REF_DEFS_VH

// Register offsets (word index on the plain port)
`define ADDR_SRC_SEL      4'h0
`define ADDR_SRC_SEL_ALT  4'h1
`define ADDR_POLARITY     4'h2
`define ADDR_FORMAT       4'h3
`define ADDR_UNIT         4'h4
`define ADDR_AUX_FUNC     4'h5
`define ADDR_CARD_CFG     4'h6
`define ADDR_RUN_STATUS   4'h7
`define ADDR_REF_OUT      4'h8
`define ADDR_CHAN_A_OUT   4'h9
`define ADDR_CHAN_B_OUT   4'ha

// Reset values
`define RST_SRC_SEL       8'h01
`define RST_SRC_SEL_ALT   8'h00
`define RST_POLARITY      8'h00
`define RST_FORMAT        8'h00
`define RST_UNIT          16'h0000
`define RST_AUX_FUNC      8'h00
`define RST_CARD_CFG      8'h00

// Setting values
`define SRC_OPTION        8'h03
`define SRC_ANALOG        8'h01
`define FMT_BCD_MAX       8'h05
`define FMT_BCD_UNSIGNED  8'h06
`define FMT_BINARY        8'h07
`define POL_BIPOLAR       8'h00
`define POL_SUM           8'h01

// Card type field in card configuration
`define CARD_NONE         3'h0
`define CARD_BIPOLAR      3'h1
`define CARD_UNIPOLAR     3'h2
`define CARD_DIG_WIDE     3'h3
`define CARD_DIG_NARROW   3'h4

// Card configuration fields
`define CFG_TYPE_LSB      0
`define CFG_TYPE_MSB      2
`define CFG_WIDE_BIT      3

`endif

// ==== src/option_ref_select.v ====
// How it works
// (R1) Operator sets source select to 3 to use the digital reference card.
// (R2) Source select resets to 1 and is frozen while running.
// (R3) Wide digital card accepts a parallel word of up to 16 bits.
// (R4) Narrow digital card accepts an 8-bit parallel word.
// (R5) Wide card decode depends on format select and the 12/16 switch.
// (R6) Format 0 to 5 decodes signed BCD, three or four digits weighted 1-2-4-8.
// (R7) Format select and display unit reset to 0, frozen while running.
// (R8) Analog polarity resets to 0 (bipolar), frozen while running.
// (R9) Bipolar card gives three channels of 14-bit magnitude plus sign.
// (R10) Source 1 with bipolar: channels 1 and 2 replace main and aux inputs. Code replaces them only when polarity is also 0.
// (R11) Operator must not assign the option/inverter select function then.
// (R12) Alt source 3 with polarity 1: sum of three bipolar channels is reference.
// (R13) Unipolar card: sum of voltage and current 14-bit channels is reference.
// (R14) Unipolar card ignores the polarity setting.
// (R15) Format 7 decodes signed binary, 12 or 16 bits across both terminal blocks.
// (R16) Sign bit 0 forward, 1 reverse; word captured only while read strobe is 1.
// (R17) Format 6 with 16 bits decodes unsigned five-digit BCD, lowest unit bit absent.
`timescale 1ns/10ps
`include "option_ref_defs.vh"

module option_ref_select (
  input wire clk_sys, // System clock, 20 MHz
  input wire resetn, // Synchronous reset, active low
  input wire [3:0] reg_addr, // Register index
  input wire [15:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata, // Read data, cycle after read strobe
  input wire drive_running, // Drive operating, same domain
  input wire [9:0] first_terminal_block, // Parallel data pins 1 to 10
  input wire [5:0] second_terminal_block, // Parallel data pins 1 to 6
  input wire sign_pin, // Direction, 1 reverse
  input wire read_strobe_pin, // Read strobe, 1 reads
  input wire [14:0] ana_ch1, // Card channel 1, sign in bit 14
  input wire [14:0] ana_ch2, // Card channel 2, sign in bit 14
  input wire [14:0] ana_ch3, // Card channel 3, sign in bit 14
  input wire [14:0] main_analog_input, // Built-in main input, signed
  input wire [14:0] aux_analog_input, // Built-in aux input, signed
  output reg [17:0] freq_ref, // Signed frequency reference
  output reg freq_ref_valid, // Reference path selected and valid
  output reg [17:0] main_chan_out, // Signed main channel used
  output reg [17:0] aux_chan_out, // Signed aux channel used
  output reg [7:0] aux_func_out, // Function of aux channel
  output reg decode_error // Illegal digit or setting seen
);

  // Settings
  reg [7:0] src_sel_q;
  reg [7:0] src_sel_alt_q;
  reg [7:0] polarity_q;
  reg [7:0] format_q;
  reg [15:0] unit_q;
  reg [7:0] aux_func_q;
  reg [7:0] card_cfg_q;

  // Pin synchronisers
  reg [17:0] pin_meta_q;
  reg [17:0] pin_sync_q;
  reg [44:0] ana_meta_q;
  reg [44:0] ana_sync_q;
  reg [44:0] ana_prev_q;
  reg [44:0] ana_hold_q;

  reg [17:0] dig_ref_q;
  reg dig_err_q;

  wire [2:0] card_type = card_cfg_q[`CFG_TYPE_MSB:`CFG_TYPE_LSB];
  wire wide_16 = card_cfg_q[`CFG_WIDE_BIT];
  wire [15:0] word = pin_sync_q[15:0];
  wire sign_s = pin_sync_q[16];
  wire strobe_s = pin_sync_q[17];

  // Sign-magnitude channel to signed 18 bits
  function [17:0] sm_to_signed;
    input [14:0] ch;
    reg [17:0] mag;
    begin
      mag = {4'h0, ch[13:0]};
      sm_to_signed = ch[14] ? (~mag + 18'h0_0001) : mag;
    end
  endfunction

  function [17:0] apply_sign;
    input [17:0] mag;
    input neg;
    begin
      apply_sign = neg ? (~mag + 18'h0_0001) : mag;
    end
  endfunction

  function digit_bad;
    input [3:0] d;
    begin
      digit_bad = (d > 4'h9);
    end
  endfunction

  // Weighted BCD accumulation of one digit
  function [17:0] bcd_step;
    input [17:0] acc;
    input [3:0] d;
    begin
      bcd_step = (acc << 3) + (acc << 1) + {14'h0000, d};
    end
  endfunction

  // Register writes, frozen while running
  wire set_wr = reg_wr && !drive_running; // R2 R7 R8
  always @(posedge clk_sys) begin
    if (!resetn) begin
      src_sel_q <= `RST_SRC_SEL; // R2
      src_sel_alt_q <= `RST_SRC_SEL_ALT;
      polarity_q <= `RST_POLARITY; // R8
      format_q <= `RST_FORMAT; // R7
      unit_q <= `RST_UNIT; // R7
      aux_func_q <= `RST_AUX_FUNC;
      card_cfg_q <= `RST_CARD_CFG;
    end else if (set_wr) begin
      case (reg_addr)
        `ADDR_SRC_SEL: begin
          src_sel_q <= reg_wdata[7:0]; // R2
        end
        `ADDR_SRC_SEL_ALT: begin
          src_sel_alt_q <= reg_wdata[7:0];
        end
        `ADDR_POLARITY: begin
          polarity_q <= reg_wdata[7:0]; // R8
        end
        `ADDR_FORMAT: begin
          format_q <= reg_wdata[7:0]; // R7
        end
        `ADDR_UNIT: begin
          unit_q <= reg_wdata; // R7
        end
        `ADDR_AUX_FUNC: begin
          aux_func_q <= reg_wdata[7:0];
        end
        `ADDR_CARD_CFG: begin
          card_cfg_q <= reg_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      pin_meta_q <= 18'h0_0000;
      pin_sync_q <= 18'h0_0000;
      ana_meta_q <= 45'h0000_0000_0000;
      ana_sync_q <= 45'h0000_0000_0000;
    end else begin
      pin_meta_q <= {read_strobe_pin, sign_pin, second_terminal_block, first_terminal_block};
      pin_sync_q <= pin_meta_q;
      ana_meta_q <= {ana_ch3, ana_ch2, ana_ch1}; // R9
      ana_sync_q <= ana_meta_q;
    end
  end

  // Bitwise synced channels may tear mid-change; take two equal samples only
  always @(posedge clk_sys) begin
    if (!resetn) begin
      ana_prev_q <= 45'h0000_0000_0000;
      ana_hold_q <= 45'h0000_0000_0000;
    end else begin
      ana_prev_q <= ana_sync_q;
      if (ana_sync_q == ana_prev_q) begin
        ana_hold_q <= ana_sync_q; // R9
      end
    end
  end

  // Digital word decode
  reg [17:0] dec_val;
  reg dec_err;
  always @* begin
    dec_val = 18'h0_0000;
    dec_err = 1'b0;
    if (card_type == `CARD_DIG_NARROW) begin
      // R4: 8-bit card, pins 1-8 data
      if (format_q == `FMT_BINARY) begin
        dec_val = apply_sign({10'h000, word[7:0]}, sign_s); // R16
      end else if (format_q <= `FMT_BCD_MAX) begin
        dec_err = digit_bad(word[3:0]) | digit_bad(word[7:4]);
        dec_val = apply_sign(bcd_step(bcd_step(18'h0_0000, word[7:4]), word[3:0]), sign_s);
      end else begin
        dec_err = 1'b1;
      end
    end else if (card_type == `CARD_DIG_WIDE) begin
      // R3 R5
      if (format_q == `FMT_BINARY) begin
        if (wide_16) begin
          dec_val = apply_sign({2'h0, word}, sign_s); // R15
        end else begin
          dec_val = apply_sign({6'h00, word[11:0]}, sign_s); // R15
        end
      end else if (format_q <= `FMT_BCD_MAX) begin
        if (wide_16) begin
          dec_err = digit_bad(word[3:0]) | digit_bad(word[7:4]) |
                    digit_bad(word[11:8]) | digit_bad(word[15:12]);
          dec_val = bcd_step(bcd_step(bcd_step(bcd_step(18'h0_0000, word[15:12]),
                    word[11:8]), word[7:4]), word[3:0]); // R6
        end else begin
          dec_err = digit_bad(word[3:0]) | digit_bad(word[7:4]) | digit_bad(word[11:8]);
          dec_val = bcd_step(bcd_step(bcd_step(18'h0_0000, word[11:8]),
                    word[7:4]), word[3:0]); // R6
        end
        dec_val = apply_sign(dec_val, sign_s); // R16
      end else if (format_q == `FMT_BCD_UNSIGNED && wide_16) begin
        // R17: pins shifted, sign pin is digit 5 bit 1, low digit unit bit is zero
        dec_err = digit_bad({word[2:0], 1'b0}) | digit_bad(word[6:3]) |
                  digit_bad(word[10:7]) | digit_bad(word[14:11]);
        dec_val = bcd_step(bcd_step(bcd_step(bcd_step(bcd_step(18'h0_0000,
                  {2'b00, sign_s, word[15]}), word[14:11]), word[10:7]), word[6:3]),
                  {word[2:0], 1'b0}); // R17
      end else begin
        dec_err = 1'b1;
      end
    end
  end

  // Capture only while the read strobe is high
  always @(posedge clk_sys) begin
    if (!resetn) begin
      dig_ref_q <= 18'h0_0000;
      dig_err_q <= 1'b0;
    end else if (strobe_s) begin
      dig_ref_q <= dec_val; // R16
      dig_err_q <= dec_err;
    end
  end

  // Analog channel selection
  wire [17:0] c1 = sm_to_signed(ana_hold_q[14:0]);
  wire [17:0] c2 = sm_to_signed(ana_hold_q[29:15]);
  wire [17:0] c3 = sm_to_signed(ana_hold_q[44:30]);
  wire [17:0] u_sum = {4'h0, ana_hold_q[13:0]} + {4'h0, ana_hold_q[28:15]};

  // Reference path selection, replacement checked before sum
  wire card_digital = (card_type == `CARD_DIG_WIDE) || (card_type == `CARD_DIG_NARROW);
  wire path_replace = (card_type == `CARD_BIPOLAR) && (src_sel_q == `SRC_ANALOG) &&
                      (polarity_q == `POL_BIPOLAR);
  wire path_sum = (card_type == `CARD_BIPOLAR) && (src_sel_alt_q == `SRC_OPTION) &&
                  (polarity_q == `POL_SUM);
  wire path_unipolar = (card_type == `CARD_UNIPOLAR) && (src_sel_q == `SRC_OPTION);
  wire path_digital = card_digital && (src_sel_q == `SRC_OPTION);
  wire path_main = (src_sel_q == `SRC_ANALOG);
  wire [17:0] main_s = {{3{main_analog_input[14]}}, main_analog_input};
  wire [17:0] aux_s = {{3{aux_analog_input[14]}}, aux_analog_input};

  reg [17:0] ref_d;
  reg ref_ok_d;
  reg [17:0] main_d;
  reg [17:0] aux_d;
  always @* begin
    ref_d = 18'h0_0000;
    ref_ok_d = 1'b0;
    main_d = main_s;
    aux_d = aux_s;
    if (path_replace) begin
      main_d = c1; // R10
      aux_d = c2; // R10
      ref_d = c1; // R10
      ref_ok_d = 1'b1;
    end else if (path_sum) begin
      ref_d = c1 + c2 + c3; // R12
      ref_ok_d = 1'b1;
    end else if (path_unipolar) begin
      ref_d = u_sum; // R13 R14
      ref_ok_d = 1'b1;
    end else if (path_digital) begin
      ref_d = dig_ref_q; // R1
      ref_ok_d = !dig_err_q;
    end else if (path_main) begin
      ref_d = main_s;
      ref_ok_d = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      freq_ref <= 18'h0_0000;
      freq_ref_valid <= 1'b0;
      main_chan_out <= 18'h0_0000;
      aux_chan_out <= 18'h0_0000;
      aux_func_out <= 8'h00;
      decode_error <= 1'b0;
    end else begin
      freq_ref <= ref_d;
      freq_ref_valid <= ref_ok_d;
      main_chan_out <= main_d;
      aux_chan_out <= aux_d;
      aux_func_out <= aux_func_q; // R10
      decode_error <= dig_err_q;
    end
  end

  // Read port
  always @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_SRC_SEL: begin
          reg_rdata <= {24'h00_0000, src_sel_q};
        end
        `ADDR_SRC_SEL_ALT: begin
          reg_rdata <= {24'h00_0000, src_sel_alt_q};
        end
        `ADDR_POLARITY: begin
          reg_rdata <= {24'h00_0000, polarity_q};
        end
        `ADDR_FORMAT: begin
          reg_rdata <= {24'h00_0000, format_q};
        end
        `ADDR_UNIT: begin
          reg_rdata <= {16'h0000, unit_q};
        end
        `ADDR_AUX_FUNC: begin
          reg_rdata <= {24'h00_0000, aux_func_q};
        end
        `ADDR_CARD_CFG: begin
          reg_rdata <= {24'h00_0000, card_cfg_q};
        end
        `ADDR_RUN_STATUS: begin
          reg_rdata <= {29'h0000_0000, decode_error, freq_ref_valid, drive_running};
        end
        `ADDR_REF_OUT: begin
          reg_rdata <= {{14{freq_ref[17]}}, freq_ref};
        end
        `ADDR_CHAN_A_OUT: begin
          reg_rdata <= {{14{main_chan_out[17]}}, main_chan_out};
        end
        `ADDR_CHAN_B_OUT: begin
          reg_rdata <= {{14{aux_chan_out[17]}}, aux_chan_out};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==== test/ext_ref_src.sv ====
`timescale 1ns/10ps
module ext_ref_src (
  input wire clk_sys, // Clock
  output reg [9:0] first_terminal_block, // Pins 1 to 10
  output reg [5:0] second_terminal_block, // Pins 1 to 6
  output reg sign_pin, // Direction
  output reg read_strobe_pin, // Read strobe
  output reg [14:0] ana_ch1, // Channel 1
  output reg [14:0] ana_ch2, // Channel 2
  output reg [14:0] ana_ch3 // Channel 3
);
  initial begin
    {second_terminal_block, first_terminal_block} = 16'h0000;
    sign_pin = 1'b0;
    read_strobe_pin = 1'b0;
    {ana_ch1, ana_ch2, ana_ch3} = 45'h0000_0000_0000;
  end
  task send(input [15:0] w, input s);
    @(posedge clk_sys);
    {second_terminal_block, first_terminal_block} <= w;
    sign_pin <= s;
    repeat (3) @(posedge clk_sys);
    read_strobe_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    read_strobe_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // Word goes stale once the hold is over
    {second_terminal_block, first_terminal_block} <= ~w;
    sign_pin <= ~s;
  endtask
  task set_ana(input [14:0] a, input [14:0] b, input [14:0] c);
    @(posedge clk_sys);
    ana_ch1 <= a;
    ana_ch2 <= b;
    ana_ch3 <= c;
  endtask
endmodule

// ==== test/option_ref_checker_asserts.sv ====
`timescale 1ns/10ps
module option_ref_checker (
  input wire clk_sys, // Clock
  input wire resetn, // Reset
  input wire [3:0] reg_addr, // Index
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata, // Read data
  input wire drive_running, // Running
  input wire [17:0] freq_ref, // Reference
  input wire freq_ref_valid, // Valid
  input wire [17:0] main_chan_out, // Main channel
  input wire [7:0] aux_func_out, // Aux function
  input wire decode_error // Error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property rd_shows(a, g, e);
    $past(reg_rd) && $past(reg_addr) == a |-> g == e;
  endproperty
  a_status_run: assert property (rd_shows(4'h7, reg_rdata[0], $past(drive_running)))
    else $error("run bit wrong");
  a_status_valid: assert property (rd_shows(4'h7, reg_rdata[1], $past(freq_ref_valid)))
    else $error("valid bit wrong");
  a_status_err: assert property (rd_shows(4'h7, reg_rdata[2], $past(decode_error)))
    else $error("error bit wrong");
  a_ref_read: assert property (rd_shows(4'h8, reg_rdata[17:0], $past(freq_ref)))
    else $error("reference readback wrong");
  a_main_read: assert property (rd_shows(4'h9, reg_rdata[17:0], $past(main_chan_out)))
    else $error("main channel readback wrong");
  a_func_frozen: assert property ($past(drive_running, 2) && $past(drive_running)
    |-> $stable(aux_func_out)) else $error("aux function moved while running");
  a_reset_clear: assert property (!$past(resetn) |-> freq_ref == 18'h0_0000
    && !freq_ref_valid && !decode_error) else $error("outputs not cleared");
  a_err_not_valid: assert property ($rose(decode_error) |-> ##[0:1] !freq_ref_valid)
    else $error("valid with bad word");
  c_error: cover property ($rose(decode_error));
  c_valid: cover property ($rose(freq_ref_valid));
  c_ref_read: cover property ($past(reg_rd) && $past(reg_addr) == 4'h8);
endmodule
bind option_ref_select option_ref_checker chk_u (.*);

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`include "option_ref_defs.vh"
module testbench;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg drive_running = 1'b0;
  reg [14:0] main_in = 15'h0123;
  reg [14:0] aux_in = 15'h7ff0;
  wire [31:0] reg_rdata;
  wire [9:0] tb1;
  wire [5:0] tb2;
  wire sgn, stb, valid, err;
  wire [14:0] c1, c2, c3;
  wire [17:0] fref, mch, ach;
  wire [7:0] afn;
  integer mismatches = 0;
  integer n_checks = 0;
  integer cycles = 0;
  initial forever #25 clk_sys = ~clk_sys;
  ext_ref_src src_u (.clk_sys(clk_sys), .first_terminal_block(tb1),
    .second_terminal_block(tb2), .sign_pin(sgn), .read_strobe_pin(stb),
    .ana_ch1(c1), .ana_ch2(c2), .ana_ch3(c3));
  option_ref_select dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_running(drive_running), .first_terminal_block(tb1),
    .second_terminal_block(tb2), .sign_pin(sgn), .read_strobe_pin(stb),
    .ana_ch1(c1), .ana_ch2(c2), .ana_ch3(c3), .main_analog_input(main_in),
    .aux_analog_input(aux_in), .freq_ref(fref), .freq_ref_valid(valid),
    .main_chan_out(mch), .aux_chan_out(ach), .aux_func_out(afn), .decode_error(err));
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function [31:0] sx(input [17:0] v);
    sx = {{14{v[17]}}, v};
  endfunction
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task dig(input [15:0] w, input s, input integer e, input bad);
    src_u.send(w, s);
    repeat (6) @(posedge clk_sys);
    #1 chk({valid, err}, {~bad, bad});
    if (!bad)
      chk(sx(fref), e);
  endtask
  task settle(input integer e);
    repeat (5) @(posedge clk_sys);
    #1 chk(sx(fref), e);
  endtask
  task t_settings;
    rd(`ADDR_SRC_SEL, 1);
    rd(`ADDR_FORMAT, 0);
    rd(`ADDR_UNIT, 0);
    rd(`ADDR_POLARITY, 0);
    chk(sx(fref), 291);
    chk(sx(mch), 291);
    chk(sx(ach), -16);
    @(posedge clk_sys);
    drive_running <= 1'b1;
    wr(`ADDR_SRC_SEL, 16'h0003);
    wr(`ADDR_FORMAT, 16'h0007);
    wr(`ADDR_POLARITY, 16'h0001);
    wr(`ADDR_UNIT, 16'h0001);
    wr(`ADDR_AUX_FUNC, 16'h0009);
    rd(`ADDR_SRC_SEL, 1);
    rd(`ADDR_FORMAT, 0);
    rd(`ADDR_POLARITY, 0);
    rd(`ADDR_UNIT, 0);
    rd(`ADDR_RUN_STATUS, 3);
    @(posedge clk_sys);
    drive_running <= 1'b0;
    $display("settings test done");
  endtask
  task t_digital;
    integer f;
    wr(`ADDR_SRC_SEL, 16'h0003);
    wr(`ADDR_CARD_CFG, 16'h000b);
    for (f = 0; f < 6; f = f + 1) begin
      wr(`ADDR_FORMAT, f[15:0]);
      dig(16'h1234 + f[15:0], 1'b1, -1234 - f, 1'b0);
    end
    dig(16'h9999, 1'b0, 9999, 1'b0);
    dig(16'h00a0, 1'b0, 0, 1'b1);
    rd(`ADDR_RUN_STATUS, 4);
    wr(`ADDR_CARD_CFG, 16'h0003);
    dig(16'hf987, 1'b0, 987, 1'b0);
    wr(`ADDR_FORMAT, 16'h0006);
    dig(16'hcccc, 1'b1, 0, 1'b1);
    wr(`ADDR_FORMAT, 16'h0007);
    dig(16'hfabc, 1'b1, -2748, 1'b0);
    wr(`ADDR_CARD_CFG, 16'h000b);
    dig(16'hffff, 1'b1, -65535, 1'b0);
    rd(`ADDR_RUN_STATUS, 2);
    wr(`ADDR_FORMAT, 16'h0006);
    dig(16'hcccc, 1'b1, 39998, 1'b0);
    wr(`ADDR_CARD_CFG, 16'h0004);
    wr(`ADDR_FORMAT, 16'h0007);
    dig(16'hff85, 1'b0, 133, 1'b0);
    wr(`ADDR_FORMAT, 16'h0000);
    dig(16'h0042, 1'b1, -42, 1'b0);
    rd(`ADDR_REF_OUT, -42);
    $display("digital test done");
  endtask
  task t_analog;
    wr(`ADDR_CARD_CFG, 16'h0001);
    wr(`ADDR_SRC_SEL, 16'h0001);
    wr(`ADDR_AUX_FUNC, 16'h0005);
    src_u.set_ana(15'h4064, 15'h0037, 15'h03e8);
    settle(-100);
    chk(sx(ach), 55);
    chk({24'h00_0000, afn}, 5);
    rd(`ADDR_CHAN_A_OUT, -100);
    rd(`ADDR_CHAN_B_OUT, 55);
    wr(`ADDR_SRC_SEL_ALT, 16'h0003);
    wr(`ADDR_POLARITY, 16'h0001);
    settle(955);
    wr(`ADDR_CARD_CFG, 16'h0002);
    wr(`ADDR_SRC_SEL, 16'h0003);
    src_u.set_ana(15'h5f40, 15'h0bb8, 15'h03e8);
    settle(11000);
    wr(`ADDR_POLARITY, 16'h0000);
    settle(11000);
    $display("analog test done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_settings;
    t_digital;
    t_analog;
    give_verdict;
  end
endmodule
